// >>> flash_host.sv
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`default_nettype none
module flash_host
	import flash_host_pkg::*;
#(
	parameter int unsigned POLL_TIMEOUT = POLL_TIMEOUT_CYC
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output logic             ack_o,
	// Flash pins.
	output logic      [16:0] address_lines_o,
	output logic             chip_sel_n_o,
	output logic             out_en_n_o,
	output logic             write_n_o,
	output logic      [7:0]  data_lines_o,
	output logic             data_lines_oe_o,
	input  wire logic [7:0]  data_lines_i
);

	typedef enum logic [2:0] {
		S_IDLE,
		S_WSETUP,
		S_WPULSE,
		S_WHOLD,
		S_WGAP,
		S_RACT,
		S_RGAP
	} state_e;

	// Number of bus writes in each command.
	function automatic logic [2:0] seq_len(input cmd_e c);
		case (c)
			CMD_PROGRAM:       seq_len = 3'd4;
			CMD_ERASE:         seq_len = 3'd6;
			CMD_LOCKOUT:       seq_len = 3'd6;
			CMD_ID_ENTRY:      seq_len = 3'd3;
			CMD_ID_EXIT:       seq_len = 3'd3;
			default:           seq_len = 3'd1;
		endcase
	endfunction

	// Address and data of one bus write of a command.
	function automatic logic [24:0] seq_word(input cmd_e c, input logic [2:0] i,
			input logic [16:0] tgt, input logic [7:0] wd);
		logic [7:0] last;
		last = CODE_ID_EXIT;
		case (c)
			CMD_ERASE:    last = CODE_CHIP_ERASE;
			CMD_LOCKOUT:  last = CODE_LOCKOUT;
			CMD_ID_ENTRY: last = CODE_ID_ENTRY;
			CMD_PROGRAM:  last = CODE_PROGRAM;
			default:      last = CODE_ID_EXIT;
		endcase
		if (c == CMD_ID_EXIT_SHORT) begin
			seq_word = {tgt, CODE_ID_EXIT};
		end else if (c == CMD_PROGRAM && i == 3'd3) begin
			seq_word = {tgt, wd};
		end else if (i == 3'd0 || i == 3'd3) begin
			seq_word = {UNLOCK_ADDR1, UNLOCK_DATA1};
		end else if (i == 3'd1 || i == 3'd4) begin
			seq_word = {UNLOCK_ADDR2, UNLOCK_DATA2};
		end else if (i == 3'd2 && (c == CMD_ERASE || c == CMD_LOCKOUT)) begin
			seq_word = {UNLOCK_ADDR1, CODE_ERASE_SETUP};
		end else begin
			seq_word = {UNLOCK_ADDR1, last};
		end
	endfunction

	function automatic logic needs_poll(input cmd_e c);
		needs_poll = (c == CMD_PROGRAM || c == CMD_ERASE || c == CMD_LOCKOUT);
	endfunction

	state_e      state_reg;
	cmd_e        cmd_reg;
	logic [2:0]  idx_reg;
	logic [7:0]  cnt_reg;
	logic        poll_reg;
	logic        have_prev_reg;
	logic        prev_bit_reg;
	logic [31:0] tmo_reg;
	logic [16:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic [7:0]  rdata_reg;
	logic        done_reg;
	logic        timeout_reg;
	logic        verify_reg;
	logic        refused_reg;
	logic [7:0]  meta_reg;
	logic [7:0]  sync_reg;

	logic        bus_req;
	logic        wr_ctrl;
	logic        wr_status;
	logic        start;
	logic        poll_done;
	logic        poll_tmo;
	logic [24:0] next_word;

	assign bus_req   = cyc_i && stb_i && !ack_o;
	assign wr_ctrl   = bus_req && we_i && sel_i[0] && adr_i == OFS_CTRL;
	assign wr_status = bus_req && we_i && sel_i[0] && adr_i == OFS_STATUS;
	// Starting is refused while busy, so a running operation is never cut short.
	assign start     = wr_ctrl && state_reg == S_IDLE && cmd_e'(dat_i[2:0]) != CMD_NONE;
	assign poll_done = state_reg == S_RACT && cnt_reg == 8'h00 && poll_reg && have_prev_reg
		&& sync_reg[TOGGLE_STATUS_BIT] == prev_bit_reg;
	assign poll_tmo  = poll_reg && tmo_reg >= POLL_TIMEOUT;
	assign next_word = seq_word(cmd_reg, idx_reg + 3'd1, addr_reg, wdata_reg);

	// Data pins are asynchronous to clk_i.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= DATA_RESET;
			sync_reg <= DATA_RESET;
		end else begin
			meta_reg <= data_lines_i;
			sync_reg <= meta_reg;
		end
	end

	// Wishbone slave: one wait state, unmapped reads return zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= bus_req;
			dat_o <= 32'h0000_0000;
			if (bus_req && !we_i) begin
				if (adr_i == OFS_CTRL) begin
					dat_o <= {29'h0000_0000, cmd_reg};
				end else if (adr_i == OFS_ADDR) begin
					dat_o <= {15'h0000, addr_reg};
				end else if (adr_i == OFS_WDATA) begin
					dat_o <= {24'h00_0000, wdata_reg};
				end else if (adr_i == OFS_RDATA) begin
					dat_o <= {24'h00_0000, rdata_reg};
				end else if (adr_i == OFS_STATUS) begin
					dat_o <= {27'h000_0000, refused_reg, verify_reg, timeout_reg, done_reg,
						state_reg != S_IDLE};
				end
			end
		end
	end

	// Operand registers; frozen while an operation runs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_reg  <= ADDR_RESET;
			wdata_reg <= DATA_RESET;
		end else if (bus_req && we_i && state_reg == S_IDLE) begin
			if (adr_i == OFS_ADDR) begin
				if (sel_i[0]) addr_reg[7:0]  <= dat_i[7:0];
				if (sel_i[1]) addr_reg[15:8] <= dat_i[15:8];
				if (sel_i[2]) addr_reg[16]   <= dat_i[16];
			end else if (adr_i == OFS_WDATA && sel_i[0]) begin
				wdata_reg <= dat_i[7:0];
			end
		end
	end

	// Sticky status; a hardware set wins over a software clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_reg    <= 1'b0;
			timeout_reg <= 1'b0;
			verify_reg  <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			if (start) begin
				done_reg    <= 1'b0;
				timeout_reg <= 1'b0;
				verify_reg  <= 1'b0;
			end else if (state_reg == S_RGAP && cnt_reg == 8'h00 && !poll_reg) begin
				done_reg <= 1'b1;
			end else if (state_reg == S_WGAP && cnt_reg == 8'h00 && !needs_poll(cmd_reg)
					&& idx_reg == seq_len(cmd_reg) - 3'd1) begin
				done_reg <= 1'b1;
			end
			if (poll_tmo && state_reg == S_RGAP && cnt_reg == 8'h00) begin
				timeout_reg <= 1'b1;
			end
			// A byte that will not read back means a 0 to 1 attempt or a locked block.
			if (poll_done && cmd_reg == CMD_PROGRAM && sync_reg != wdata_reg) begin
				verify_reg <= 1'b1;
			end
			if (wr_ctrl && !start) begin
				refused_reg <= 1'b1;
			end else if (wr_status && dat_i[ST_REFUSED_BIT]) begin
				refused_reg <= 1'b0;
			end
		end
	end

	// Pin sequencer.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg       <= S_IDLE;
			cmd_reg         <= CMD_READ;
			idx_reg         <= 3'd0;
			cnt_reg         <= 8'h00;
			poll_reg        <= 1'b0;
			have_prev_reg   <= 1'b0;
			prev_bit_reg    <= 1'b0;
			tmo_reg         <= 32'h0000_0000;
			rdata_reg       <= DATA_RESET;
			address_lines_o <= ADDR_RESET;
			chip_sel_n_o    <= 1'b1;
			out_en_n_o      <= 1'b1;
			write_n_o       <= 1'b1;
			data_lines_o    <= DATA_RESET;
			data_lines_oe_o <= 1'b0;
		end else begin
			tmo_reg <= poll_reg ? tmo_reg + 32'h0000_0001 : 32'h0000_0000;
			case (state_reg)
				S_IDLE: begin
					if (start) begin
						cmd_reg       <= cmd_e'(dat_i[2:0]);
						idx_reg       <= 3'd0;
						have_prev_reg <= 1'b0;
						poll_reg      <= 1'b0;
						if (cmd_e'(dat_i[2:0]) == CMD_READ) begin
							address_lines_o <= addr_reg;
							chip_sel_n_o    <= 1'b0;
							out_en_n_o      <= 1'b0;
							cnt_reg         <= 8'(READ_CYC - 1);
							state_reg       <= S_RACT;
						end else begin
							{address_lines_o, data_lines_o} <=
								seq_word(cmd_e'(dat_i[2:0]), 3'd0, addr_reg, wdata_reg);
							state_reg <= S_WSETUP;
						end
					end
				end
				S_WSETUP: begin
					// Output enable stays high through every write cycle.
					out_en_n_o      <= 1'b1;
					chip_sel_n_o    <= 1'b0;
					data_lines_oe_o <= 1'b1;
					state_reg       <= S_WPULSE;
					cnt_reg         <= 8'(WE_LOW_CYC - 1);
				end
				S_WPULSE: begin
					// Address settles two cycles and chip select one cycle before the strobe falls; data holds past its rise.
					write_n_o <= 1'b0;
					if (cnt_reg == 8'h00 && !write_n_o) begin
						write_n_o <= 1'b1;
						state_reg <= S_WHOLD;
					end else if (!write_n_o) begin
						cnt_reg <= cnt_reg - 8'h01;
					end
				end
				S_WHOLD: begin
					chip_sel_n_o <= 1'b1;
					cnt_reg      <= 8'(GAP_CYC - 1);
					state_reg    <= S_WGAP;
				end
				S_WGAP: begin
					data_lines_oe_o <= 1'b0;
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (idx_reg != seq_len(cmd_reg) - 3'd1) begin
						// Every write is sent whole, so the device never sees a partial match.
						idx_reg <= idx_reg + 3'd1;
						{address_lines_o, data_lines_o} <= next_word;
						state_reg <= S_WSETUP;
					end else if (needs_poll(cmd_reg)) begin
						// Polling reads the target so bit 7 and bit 6 both report status.
						poll_reg        <= 1'b1;
						address_lines_o <= addr_reg;
						chip_sel_n_o    <= 1'b0;
						out_en_n_o      <= 1'b0;
						cnt_reg         <= 8'(READ_CYC - 1);
						state_reg       <= S_RACT;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				S_RACT: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else begin
						// Deselect floats the device outputs before the next access.
						chip_sel_n_o  <= 1'b1;
						out_en_n_o    <= 1'b1;
						rdata_reg     <= sync_reg;
						prev_bit_reg  <= sync_reg[TOGGLE_STATUS_BIT];
						have_prev_reg <= 1'b1;
						if (poll_done) begin
							poll_reg <= 1'b0;
						end
						cnt_reg   <= 8'(GAP_CYC - 1);
						state_reg <= S_RGAP;
					end
				end
				S_RGAP: begin
					if (cnt_reg != 8'h00) begin
						cnt_reg <= cnt_reg - 8'h01;
					end else if (poll_tmo) begin
						poll_reg  <= 1'b0;
						state_reg <= S_IDLE;
					end else if (poll_reg) begin
						chip_sel_n_o <= 1'b0;
						out_en_n_o   <= 1'b0;
						cnt_reg      <= 8'(READ_CYC - 1);
						state_reg    <= S_RACT;
					end else begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

endmodule // flash_host
`default_nettype wire

// >>> flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;

	// Clock and pin timing.
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned WE_LOW_NS     = 60;
	localparam int unsigned READ_ACC_NS   = 150;
	localparam int unsigned GAP_NS        = 40;
	localparam int unsigned SYNC_STAGES   = 2;
	localparam int unsigned WE_LOW_CYC    = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned READ_CYC      =
		(READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int unsigned GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned ERASE_CYCLE_TIME_S = 10;
	localparam int unsigned POLL_TIMEOUT_CYC   = ERASE_CYCLE_TIME_S * CLK_HZ;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ADDR   = 8'h04;
	localparam logic [7:0] OFS_WDATA  = 8'h08;
	localparam logic [7:0] OFS_RDATA  = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Status bit positions.
	localparam int unsigned ST_BUSY_BIT    = 0;
	localparam int unsigned ST_DONE_BIT    = 1;
	localparam int unsigned ST_TIMEOUT_BIT = 2;
	localparam int unsigned ST_VERIFY_BIT  = 3;
	localparam int unsigned ST_REFUSED_BIT = 4;
	localparam int unsigned POLL_BIT       = 7;
	localparam int unsigned TOGGLE_STATUS_BIT = 6;

	// Reset values.
	localparam logic [16:0] ADDR_RESET  = 17'h00000;
	localparam logic [7:0]  DATA_RESET  = 8'h00;

	// Command bus cycles.
	localparam logic [16:0] UNLOCK_ADDR1 = 17'h05555;
	localparam logic [16:0] UNLOCK_ADDR2 = 17'h02AAA;
	localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0]  CODE_ERASE_SETUP = 8'h80;
	localparam logic [7:0]  CODE_CHIP_ERASE  = 8'h10;
	localparam logic [7:0]  CODE_LOCKOUT     = 8'h40;
	localparam logic [7:0]  CODE_PROGRAM     = 8'hA0;
	localparam logic [7:0]  CODE_ID_ENTRY    = 8'h90;
	localparam logic [7:0]  CODE_ID_EXIT     = 8'hF0;

	typedef enum logic [2:0] {
		CMD_READ,
		CMD_PROGRAM,
		CMD_ERASE,
		CMD_LOCKOUT,
		CMD_ID_ENTRY,
		CMD_ID_EXIT,
		CMD_ID_EXIT_SHORT,
		CMD_NONE
	} cmd_e;

endpackage
`default_nettype wire

// >>> flash_host_monitor.sv
`default_nettype none
module flash_host_monitor (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	input wire logic [16:0] address_lines_o,
	input wire logic        chip_sel_n_o,
	input wire logic        out_en_n_o,
	input wire logic        write_n_o,
	input wire logic [7:0]  data_lines_o,
	input wire logic        data_lines_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing after request");
	chk_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not zero without ack");
	chk_strobe_width: assert property ($fell(write_n_o) |-> !write_n_o[*3] ##1 write_n_o)
		else $error("write strobe width wrong");
	chk_addr_setup: assert property ($fell(write_n_o) |-> $past(!chip_sel_n_o) && $stable(address_lines_o))
		else $error("address or select not set before strobe");
	chk_data_hold: assert property ($rose(write_n_o) |-> data_lines_oe_o && $stable(data_lines_o) && $stable(address_lines_o))
		else $error("data or address moved at strobe rise");
	chk_write_inhibit: assert property (!write_n_o |-> out_en_n_o && !chip_sel_n_o && data_lines_oe_o)
		else $error("write strobe with output enable low");
	chk_read_ctl: assert property (!out_en_n_o |-> write_n_o && !data_lines_oe_o && !chip_sel_n_o)
		else $error("read with strobe low or bus driven");
	chk_read_len: assert property ($fell(out_en_n_o) |-> !out_en_n_o[*8])
		else $error("read access too short");
	chk_reset_idle: assert property ($fell(rst_i) |-> chip_sel_n_o && out_en_n_o && write_n_o && !data_lines_oe_o && !ack_o)
		else $error("pins not idle after reset");
endmodule // flash_host_monitor
bind flash_host flash_host_monitor mon_u (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
	.address_lines_o(address_lines_o), .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
	.write_n_o(write_n_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o)
);
`default_nettype wire

// >>> flash_dev_model.sv
`default_nettype none
module flash_dev_model #(
	parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'hC3, // Arbitrary value.
	parameter int         PROG_NS  = 2000,
	parameter int         ERASE_NS = 8000
) (
	input  wire logic [16:0] addr_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [7:0]  din_i,
	output logic      [7:0]  dout_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:131071];
	logic [16:0] wa;
	logic [7:0]  last, held;
	logic [2:0]  step;
	logic        busy, tog, locked, id_mode, pend;
	time         t_fall;
	wire logic   wr_n = we_n_i | ce_n_i;
	wire logic   rd_n = ce_n_i | oe_n_i;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		{step, busy, tog, locked, id_mode, pend} = '0;
		last = 8'h00;
		held = 8'h00;
	end
	task automatic take(input logic [16:0] a, input logic [7:0] d);
		logic [10:0] hit;
		hit = (a == ((step == 1 || step == 4) ? 17'h02AAA : 17'h05555)) ? {step, d} : 11'h0;
		step = 3'd0;
		if (pend) begin
			pend = 1'b0;
			if (!(locked && a <= 17'h01FFF)) mem[a] = mem[a] & d;
			last = d;
			busy = 1'b1;
			busy <= #(PROG_NS) 1'b0;
		end else if (d == 8'hF0 && hit[10:8] != 3'd2) id_mode = 1'b0;
		else case (hit)
			{3'd0, 8'hAA}, {3'd1, 8'h55}, {3'd3, 8'hAA}, {3'd4, 8'h55}: step = hit[10:8] + 3'd1;
			{3'd2, 8'h80}: step = 3'd3;
			{3'd2, 8'hA0}: pend = 1'b1;
			{3'd2, 8'h90}: id_mode = 1'b1;
			{3'd2, 8'hF0}: id_mode = 1'b0;
			{3'd5, 8'h40}: locked = 1'b1;
			{3'd5, 8'h10}: begin
				for (int i = 0; i < 131072; i++)
					if (!locked || i > 'h1FFF) mem[i] = 8'hFF;
				last = 8'hFF;
				busy = 1'b1;
				busy <= #(ERASE_NS) 1'b0;
			end
			default: ;
		endcase
	endtask
	always @(negedge wr_n) begin
		wa = addr_i;
		t_fall = $time;
	end
	always @(posedge wr_n)
		if (oe_n_i && !busy && $time - t_fall >= 15) take(wa, din_i);
	always @(negedge rd_n)
		if (busy) tog = ~tog;
	// Released lines show the inverse of the last byte so a stale value never passes.
	always begin
		#1;
		if (rd_n) dout_o = ~held;
		else begin
			if (busy) dout_o = {~last[7], tog, last[5:0]};
			else if (id_mode && addr_i <= 17'h2)
				dout_o = addr_i[1] ? {7'h00, locked} : addr_i[0] ? DEV_CODE : MFR_CODE;
			else dout_o = mem[addr_i];
			held = dout_o;
		end
	end
endmodule // flash_dev_model
`default_nettype wire

// >>> test_flash_host.sv
`default_nettype none
module test_flash_host;
	import flash_host_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MFR = 8'h5A; // Arbitrary value.
	localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
	logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
	logic [7:0]  adr_i, data_lines_o, data_lines_i;
	logic [31:0] dat_i, dat_o;
	logic [3:0]  sel_i;
	logic [16:0] address_lines_o;
	logic        chip_sel_n_o, out_en_n_o, write_n_o, data_lines_oe_o, locked;
	logic [7:0]  shadow [int];
	logic [16:0] used [$];
	int          failures, checked;
	flash_host #(.POLL_TIMEOUT(2000)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
		.address_lines_o(address_lines_o), .chip_sel_n_o(chip_sel_n_o),
		.out_en_n_o(out_en_n_o), .write_n_o(write_n_o), .data_lines_o(data_lines_o),
		.data_lines_oe_o(data_lines_oe_o), .data_lines_i(data_lines_i)
	);
	flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) dev_u (
		.addr_i(address_lines_o), .ce_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
		.we_n_i(write_n_o), .din_i(data_lines_o), .dout_o(data_lines_i)
	);
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic give_verdict();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			give_verdict();
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Polling status keeps the bench blind to how long the device takes.
	task automatic op(input cmd_e c, input logic [16:0] a, input logic [7:0] d,
			output logic [31:0] st);
		int n;
		wb(1'b1, OFS_ADDR, {15'h0, a}, st);
		wb(1'b1, OFS_WDATA, {24'h0, d}, st);
		wb(1'b1, OFS_CTRL, {29'h0, c}, st);
		n = 0;
		do begin
			wb(1'b0, OFS_STATUS, 32'h0, st);
			n++;
		end while (st[ST_BUSY_BIT] !== 1'b0 && n < 3000);
		if (n >= 3000) begin
			failures++;
			give_verdict();
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [16:0] a);
		return shadow.exists(a) ? shadow[a] : 8'hFF;
	endfunction
	function automatic logic [7:0] idv(input int k);
		return (k == 0) ? MFR : (k == 1) ? DEV : {7'h00, locked};
	endfunction
	task automatic rdchk(input logic [16:0] a, input logic [7:0] e);
		logic [31:0] q;
		op(CMD_READ, a, 8'h00, q);
		wb(1'b0, OFS_RDATA, 32'h0, q);
		chk({24'h0, q[7:0]}, {24'h0, e});
	endtask
	task automatic prog(input logic [16:0] a, input logic [7:0] d);
		logic [31:0] st;
		logic [7:0]  e;
		e = (locked && a <= 17'h01FFF) ? exp_rd(a) : exp_rd(a) & d;
		op(CMD_PROGRAM, a, d, st);
		chk({29'h0, st[3:1]}, {29'h0, e != d, 2'b01});
		shadow[a] = e;
		rdchk(a, e);
	endtask
	initial begin
		logic [31:0] q;
		logic [16:0] a;
		{failures, checked} = '0;
		{rst_i, locked, cyc_i, stb_i, we_i} = 5'b10000;
		sel_i = 4'hF;
		adr_i = 8'h00;
		dat_i = 32'h0;
		q = $urandom(96518);
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rdchk(17'h1ABCD, 8'hFF);
		wb(1'b0, 8'h20, 32'h0, q);
		chk(q, 32'h0);
		op(CMD_NONE, 17'h0, 8'h0, q);
		chk({31'h0, q[ST_REFUSED_BIT]}, 32'h1);
		wb(1'b1, OFS_STATUS, 32'h10, q);
		wb(1'b0, OFS_STATUS, 32'h0, q);
		chk({31'h0, q[ST_REFUSED_BIT]}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? 17'h01FFF : (i == 1) ? 17'h1FFFF : 17'h02000 + 17'($urandom_range(0, 'h1DFFF));
			used.push_back(a);
			prog(a, 8'($urandom));
			prog(a, 8'($urandom));
		end
		for (int x = 0; x < 2; x++) begin
			if (x == 1) begin
				op(CMD_LOCKOUT, 17'h0, 8'h0, q);
				chk({31'h0, q[ST_DONE_BIT]}, 32'h1);
				locked = 1'b1;
			end
			op(CMD_ID_ENTRY, 17'h0, 8'h0, q);
			for (int k = 0; k < 3; k++) rdchk(17'(k), idv(k));
			op(x ? CMD_ID_EXIT_SHORT : CMD_ID_EXIT, 17'h0, 8'hF0, q);
			rdchk(used[2], exp_rd(used[2]));
		end
		used.push_back(17'h02000);
		prog(17'h01FFF, 8'h00);
		prog(17'($urandom_range(0, 'h1FFE)), 8'h00);
		prog(17'h02000, 8'($urandom));
		op(CMD_ERASE, 17'h0, 8'h0, q);
		chk({30'h0, q[2:1]}, 32'h1);
		foreach (used[i]) begin
			if (used[i] > 17'h01FFF) shadow[used[i]] = 8'hFF;
			rdchk(used[i], exp_rd(used[i]));
		end
		give_verdict();
	end
endmodule // test_flash_host
`default_nettype wire
